//--- addr_decoder_params.svh
// Address map and configuration word constants for the system address decoder
`ifndef ADDR_DECODER_PARAMS_SVH
`define ADDR_DECODER_PARAMS_SVH

`define CODE_BASE        32'h0000_0000
`define CODE_LAST        32'h0007_FFFF
`define APP_LAST_LARGE   32'h0006_FFFF
`define APP_LAST_SMALL   32'h0002_FFFF
`define NVDATA_BASE      32'h0007_0000
`define NVDATA_LAST      32'h0007_7FFF
`define BOOT_BASE        32'h0007_8000
`define BOOT_LAST        32'h0007_DFFF
`define INFO_BASE        32'h0007_E000
`define INFO_LAST        32'h0007_FFFF
`define INFO_USER_LAST   32'h0007_EEFF
`define RAM_LOW_BASE     32'h2000_3800
`define RAM_LOW_LAST     32'h2000_77FF
`define RAM_HIGH_BASE    32'h2000_7800
`define RAM_HIGH_LAST    32'h2000_7FFF
`define PERIPH_BASE      32'h4000_0000
`define PERIPH_LAST      32'h4000_FFFF
`define TIMER_BASE       32'h4000_2000
`define TIMER_LAST       32'h4000_2FFF
`define UART_BASE        32'h4000_3000
`define UART_LAST        32'h4000_3FFF
`define SPI_BASE         32'h4000_4000
`define SPI_LAST         32'h4000_43FF
`define SCS_BASE         32'hE000_C000
`define SCS_LAST         32'hE000_FFFF
`define UNIT_SHIFT       10
`define UNIT_MASK        32'h0000_03FF
`define UNIT_SEL_LSB     10
`define UNIT_SEL_MSB     11
`define UNIT_COUNT       4

`define CFG_RESET_BIT    3
`define CFG_DEBUG_BIT    4
`define CFG_BOOT_BIT     6
`define CFG_READ_BIT     7
`define CFG_FLAG_MSB     31
`define CFG_FLAG_LSB     28
`define CFG_FLAG_VALUE   4'h4
`define CFG_DEFAULT      32'h4FFF_0FD5

`endif

//--- addr_decoder_pkg.sv
// Types shared by the system address decoder
package addr_decoder_pkg;

  typedef enum logic [3:0] {
    TGT_NONE     = 4'h0,
    TGT_PROGRAM  = 4'h1,
    TGT_NVDATA   = 4'h2,
    TGT_BOOT     = 4'h3,
    TGT_INFO     = 4'h4,
    TGT_RAM_LOW  = 4'h5,
    TGT_RAM_HIGH = 4'h6,
    TGT_TIMER    = 4'h7,
    TGT_UART     = 4'h8,
    TGT_SPI      = 4'h9,
    TGT_PERIPH   = 4'hA,
    TGT_SCS      = 4'hB
  } target_t;

  typedef enum logic [2:0] {
    ACC_READ_WRITE  = 3'h0,
    ACC_READ_CLEAR  = 3'h1,
    ACC_WRITE_ONE   = 3'h2,
    ACC_SAFE_WO     = 3'h3,
    ACC_SAFE_RW     = 3'h4,
    ACC_FIXED_RO    = 3'h5,
    ACC_WRITE_ONLY  = 3'h6
  } access_t;

endpackage : addr_decoder_pkg

//--- bus_master_model.sv
// Bus master model issuing single read and write accesses
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic        sys_clk,
  output logic [31:0]      busAddr,
  output logic             busRead,
  output logic             busWrite,
  output logic [31:0]      busWdata,
  input  wire logic [31:0] busRdata
);
  // Idle bus at time zero
  initial
  begin
    {busRead, busWrite} = 2'h0;
    busAddr = 32'hFFFF_FFFF;
    busWdata = 32'h0;
  end

  // Present one access after an edge and let the decode settle
  task start(input logic [31:0] a, input logic r, input logic [31:0] wd);
    @(posedge sys_clk);
    busAddr <= a;
    busRead <= r;
    busWrite <= !r;
    busWdata <= wd;
    #1;
  endtask : start

  // Release at the taking edge, scramble the idle bus, capture read data
  task finish(output logic [31:0] d);
    @(posedge sys_clk);
    {busRead, busWrite} <= 2'h0;
    busAddr <= ~busAddr;
    busWdata <= ~busWdata;
    #1 d = busRdata;
  endtask : finish
endmodule : bus_master_model

//--- system_address_decoder.sv
// System address decoder with configuration word and shared bit access semantics
// How it works
// - Lowest 512KB code region goes to the program store.
// - Data region addresses select the 18KB SRAM.
// - Peripheral window addresses go to on-chip peripheral modules.
// - System window addresses go to the system control space.
// - Larger variant: application area is the first 448KB.
// - Smaller variant: application area is the first 192KB.
// - 32KB user data area sits above the application area.
// - 24KB boot area sits above the user data area.
// - Top 8KB of code region is the configuration area.
// - Lower 16KB retained bank at bottom of data region.
// - Upper 2KB retained bank at top of data region.
// - Register address is peripheral base plus register offset.
// - Timers, serial ports and SPI decoded at their bases.
// - Config bits 3 reset pin, 4 debug, 6 boot enable.
// - Config bit 7 low blocks programmer readout.
// - Debug on only with debug 1, reset pin 0, read 1.
// - Config word valid only when top nibble holds flag pattern.
// - Read-to-clear bit returns value then clears on read.
// - Write-one-clear bit clears on one, keeps on zero.
// - Protected bits written only in safe mode; only the safe-mode readable one reads back.
// - Write-only bits read zero; fixed bits ignore reset.
// - Debug pins serve only debug while debug is enabled.
`timescale 1ns/1ps
`include "addr_decoder_params.svh"

module system_address_decoder
  import addr_decoder_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Bus access from the masters
  input  wire logic [31:0] busAddr,
  input  wire logic        busRead,
  input  wire logic        busWrite,
  input  wire logic [31:0] busWdata,
  output logic [31:0]      busRdata,
  // Part variant: 1 selects the larger application area
  input  wire logic        largeVariant,
  // Configuration word as loaded from the configuration area
  input  wire logic [31:0] cfgWord,
  input  wire logic        cfgLoad,
  // Target selection
  output logic [3:0]       targetSel,
  output logic [1:0]       unitIndex,
  output logic [31:0]      regOffset,
  output logic             progStoreSel,
  output logic             appAreaSel,
  output logic             ramSel,
  output logic             periphSel,
  output logic             scsSel,
  output logic             decodeMiss,
  output logic             cfgUserArea,
  // Configuration outputs
  output logic             config_valid_flag,
  output logic             resetPinEn,
  output logic             debugCfgEn,
  output logic             bootEn,
  output logic             readoutEn,
  output logic             debugActive,
  output logic             debugPinsOwned,
  // Shared status bits, one of each access kind except read-write and write-only
  input  wire logic        safeMode,
  input  wire logic        read_to_clear_set,
  input  wire logic        write_one_clear_set,
  input  wire logic [2:0]  bitSelect,
  output logic             read_to_clear,
  output logic             write_one_clear,
  output logic             safe_mode_write_only,
  output logic             safe_mode_write_readable,
  output logic             fixed_read_only
);

  //--------------------------------------------------------------
  // Address decode
  //--------------------------------------------------------------
  logic    inCode;
  logic    inApp;
  logic    inNvData;
  logic    inBoot;
  logic    inInfo;
  logic    inRamLow;
  logic    inRamHigh;
  logic    inTimer;
  logic    inUart;
  logic    inSpi;
  logic    inPeriph;
  logic    inScs;
  logic [31:0] appLast;
  target_t tgt;

  //--------------------------------------------------------------
  // Timer and serial port unit decode
  //--------------------------------------------------------------
  logic [3:0] timerHit;
  logic [3:0] uartHit;
  logic [1:0] unitCode;

  // One compare pair per 1KB unit, four units of each kind
  genvar u;
  generate
    for (u = 0; u < `UNIT_COUNT; u++)
    begin : g_unit
      logic [31:0] timerBase;
      logic [31:0] uartBase;
      assign timerBase   = `TIMER_BASE + (32'(u) << `UNIT_SHIFT);
      assign uartBase    = `UART_BASE + (32'(u) << `UNIT_SHIFT);
      assign timerHit[u] = busAddr >= timerBase && busAddr <= timerBase + `UNIT_MASK;
      assign uartHit[u]  = busAddr >= uartBase && busAddr <= uartBase + `UNIT_MASK;
    end
  endgenerate

  // One-hot unit hit to unit number
  always_comb
  begin
    unitCode = 2'h0;
    for (int k = 0; k < `UNIT_COUNT; k++)
    begin
      if (timerHit[k] || uartHit[k])
        unitCode = 2'(k);
    end
  end

  // Code region and its sub-areas
  assign appLast  = largeVariant ? `APP_LAST_LARGE : `APP_LAST_SMALL;
  assign inCode   = busAddr <= `CODE_LAST;
  assign inApp    = busAddr <= appLast;
  assign inNvData = busAddr >= `NVDATA_BASE && busAddr <= `NVDATA_LAST;
  assign inBoot   = busAddr >= `BOOT_BASE && busAddr <= `BOOT_LAST;
  assign inInfo   = busAddr >= `INFO_BASE && busAddr <= `INFO_LAST;

  // Data region banks
  assign inRamLow  = busAddr >= `RAM_LOW_BASE && busAddr <= `RAM_LOW_LAST;
  assign inRamHigh = busAddr >= `RAM_HIGH_BASE && busAddr <= `RAM_HIGH_LAST;

  // Peripheral window and unit bases
  assign inPeriph = busAddr >= `PERIPH_BASE && busAddr <= `PERIPH_LAST;
  assign inTimer  = |timerHit;
  assign inUart   = |uartHit;
  assign inSpi    = busAddr >= `SPI_BASE && busAddr <= `SPI_LAST;
  assign inScs    = busAddr >= `SCS_BASE && busAddr <= `SCS_LAST;

  // Priority of targets; anything else is reserved
  always_comb
  begin
    if (inApp)
      tgt = TGT_PROGRAM;
    else if (inNvData)
      tgt = TGT_NVDATA;
    else if (inBoot)
      tgt = TGT_BOOT;
    else if (inInfo)
      tgt = TGT_INFO;
    else if (inCode)
      tgt = TGT_PROGRAM;                 // Gap above small application area
    else if (inRamLow)
      tgt = TGT_RAM_LOW;
    else if (inRamHigh)
      tgt = TGT_RAM_HIGH;
    else if (inTimer)
      tgt = TGT_TIMER;
    else if (inUart)
      tgt = TGT_UART;
    else if (inSpi)
      tgt = TGT_SPI;
    else if (inPeriph)
      tgt = TGT_PERIPH;
    else if (inScs)
      tgt = TGT_SCS;
    else
      tgt = TGT_NONE;
  end

  // Group selects and register offset within a unit
  assign targetSel    = tgt;
  assign progStoreSel = inCode;
  assign appAreaSel   = inApp;
  assign ramSel       = inRamLow | inRamHigh;
  assign periphSel    = inPeriph;
  assign scsSel       = inScs;
  assign decodeMiss   = (tgt == TGT_NONE) & (busRead | busWrite);
  assign cfgUserArea  = busAddr >= `INFO_BASE && busAddr <= `INFO_USER_LAST;
  assign unitIndex    = unitCode;
  assign regOffset    = (inTimer | inUart | inSpi) ? (busAddr & `UNIT_MASK) : 32'h0;

  //--------------------------------------------------------------
  // Configuration word
  //--------------------------------------------------------------
  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic        cfgOk;
  logic        cfgTake;

  // Words without the flag pattern are refused
  assign cfgOk   = cfgWord[`CFG_FLAG_MSB:`CFG_FLAG_LSB] == `CFG_FLAG_VALUE;
  assign cfgTake = cfgLoad && cfgOk;
  assign cfg_nxt = cfgTake ? cfgWord : cfg_r;

  // Holds defaults until a valid word is loaded
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cfg_r <= `CFG_DEFAULT;
    else
      cfg_r <= cfg_nxt;
  end

  // Decoded configuration fields
  assign config_valid_flag = cfg_r[`CFG_FLAG_MSB:`CFG_FLAG_LSB] == `CFG_FLAG_VALUE;
  assign resetPinEn     = cfg_r[`CFG_RESET_BIT];
  assign debugCfgEn     = cfg_r[`CFG_DEBUG_BIT];
  assign bootEn         = cfg_r[`CFG_BOOT_BIT];
  assign readoutEn      = cfg_r[`CFG_READ_BIT];
  assign debugActive    = debugCfgEn & ~resetPinEn & readoutEn;
  assign debugPinsOwned = debugActive;

  //--------------------------------------------------------------
  // Shared access bits
  //--------------------------------------------------------------
  logic rzBit_r;
  logic rzBit_nxt;
  logic w1Bit_r;
  logic w1Bit_nxt;
  logic waBit_r;
  logic waBit_nxt;
  logic rwaBit_r;
  logic rwaBit_nxt;
  logic bitHit;
  logic rdRz;
  logic wrW1;
  logic wrSafe;
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;
  logic        fixedVal;
  logic        selRz;
  logic        selW1;
  logic        selWo;
  logic        selRw;
  logic        rdHit;
  logic        wrHit;

  //--------------------------------------------------------------
  // Status bit select decode
  //--------------------------------------------------------------
  // Access kind chosen by the select code
  assign selRz    = bitSelect == ACC_READ_CLEAR;
  assign selW1    = bitSelect == ACC_WRITE_ONE;
  assign selWo    = bitSelect == ACC_SAFE_WO;
  assign selRw    = bitSelect == ACC_SAFE_RW;

  // Bits sit in the system control space, one per select code 1 to 5
  assign bitHit   = inScs;
  assign rdHit    = bitHit & busRead;
  assign wrHit    = bitHit & busWrite;
  assign rdRz     = rdHit & selRz;
  assign wrW1     = wrHit & selW1 & busWdata[0];
  assign wrSafe   = wrHit & safeMode;
  assign fixedVal = 1'b1;                // Tied, unaffected by reset

  // Set wins over the clearing access
  assign rzBit_nxt  = read_to_clear_set | (rzBit_r & ~rdRz);
  assign w1Bit_nxt  = write_one_clear_set | (w1Bit_r & ~wrW1);
  assign waBit_nxt  = (wrSafe && selWo) ? busWdata[0] : waBit_r;
  assign rwaBit_nxt = (wrSafe && selRw) ? busWdata[0] : rwaBit_r;

  //--------------------------------------------------------------
  // Read data
  //--------------------------------------------------------------
  // Read data; reserved space and write-only bits read zero
  always_comb
  begin
    rdata_nxt = 32'h0;
    if (rdHit)
    begin
      unique case (bitSelect)
        ACC_READ_CLEAR: rdata_nxt = {31'h0, rzBit_r};
        ACC_WRITE_ONE:  rdata_nxt = {31'h0, w1Bit_r};
        ACC_SAFE_RW:    rdata_nxt = {31'h0, rwaBit_r};
        ACC_FIXED_RO:   rdata_nxt = {31'h0, fixedVal};
        default:        rdata_nxt = 32'h0;
      endcase
    end
  end

  //--------------------------------------------------------------
  // Status bit storage
  //--------------------------------------------------------------
  // Read-to-clear bit
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rzBit_r <= 1'b0;
    else
      rzBit_r <= rzBit_nxt;
  end

  // Write-one-clear bit
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      w1Bit_r <= 1'b0;
    else
      w1Bit_r <= w1Bit_nxt;
  end

  // Safe-mode write-only bit
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      waBit_r <= 1'b0;
    else
      waBit_r <= waBit_nxt;
  end

  // Safe-mode readable bit
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rwaBit_r <= 1'b0;
    else
      rwaBit_r <= rwaBit_nxt;
  end

  // Registered read data, valid the cycle after the read
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rdata_r <= 32'h0;
    else
      rdata_r <= rdata_nxt;
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  // Read data and status bit values
  assign busRdata                 = rdata_r;
  assign read_to_clear            = rzBit_r;
  assign write_one_clear          = w1Bit_r;
  assign safe_mode_write_only     = waBit_r;
  assign safe_mode_write_readable = rwaBit_r;
  assign fixed_read_only          = fixedVal;

endmodule : system_address_decoder

//--- system_address_decoder_bench.sv
// Self-checking bench for the system address decoder
`timescale 1ns/1ps
module system_address_decoder_bench;
  import addr_decoder_pkg::*;
  logic        sys_clk = 1'h0;
  logic        rst = 1'h1;
  logic [31:0] busAddr, busWdata, busRdata, cfgWord, regOffset, rdData;
  logic        busRead, busWrite, largeVariant, cfgLoad, safeMode, cfgUserArea;
  logic        read_to_clear_set, write_one_clear_set, decodeMiss, debugPinsOwned;
  logic [2:0]  bitSelect;
  logic [3:0]  targetSel;
  logic [1:0]  unitIndex;
  logic        progStoreSel, appAreaSel, ramSel, periphSel, scsSel, config_valid_flag;
  logic        resetPinEn, debugCfgEn, bootEn, readoutEn, debugActive, fixed_read_only;
  logic        read_to_clear, write_one_clear, safe_mode_write_only, safe_mode_write_readable;
  int          err_total = 0;
  int          samples_checked = 0;
  logic [31:0] addrs [17] = '{32'h0006_FFFF, 32'h0007_0000, 32'h0007_DFFF, 32'h0007_E000,
    32'h0008_0000, 32'h2000_37FF, 32'h2000_3800, 32'h2000_77FF, 32'h2000_7800, 32'h2000_8000,
    32'h4000_1000, 32'h4000_2C04, 32'h4000_3800, 32'h4000_4000, 32'h4001_0000, 32'hE000_C000,
    32'hE001_0000};
  logic [3:0]  tgts [17] = '{TGT_PROGRAM, TGT_NVDATA, TGT_BOOT, TGT_INFO, TGT_NONE, TGT_NONE,
    TGT_RAM_LOW, TGT_RAM_LOW, TGT_RAM_HIGH, TGT_NONE, TGT_PERIPH, TGT_TIMER, TGT_UART, TGT_SPI,
    TGT_NONE, TGT_SCS, TGT_NONE};
  logic [31:0] cfgs [6] = '{32'h5000_0008, 32'h4000_0098, 32'h4000_0050, 32'h4000_0090,
    32'hF000_0000, 32'h4000_0088};
  logic [4:0]  cfgExp [6] = '{5'h0F, 5'h1A, 5'h0C, 5'h0B, 5'h0B, 5'h12};

  system_address_decoder i_dut (.*);
  bus_master_model i_master (.*);

  // Clock at 40 MHz
  always #12.5 sys_clk = ~sys_clk;

  // Compare and count
  task chk(input string name, input logic [31:0] expv, input logic [31:0] seen);
    samples_checked++;
    if (seen !== expv)
    begin
      $display("Error %s expected %h seen %h", name, expv, seen);
      err_total++;
    end
  endtask : chk

  // One status access in the system window
  task access(input logic r, input logic [31:0] wd, input logic [2:0] sel);
    @(posedge sys_clk);
    bitSelect <= sel;
    i_master.start(32'hE000_C000, r, wd);
    i_master.finish(rdData);
  endtask : access

  // Report counts and end the run
  task give_verdict;
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // Cut a hung run short
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    give_verdict;
  end

  // Main sequence
  initial
  begin
    {largeVariant, cfgLoad, safeMode, read_to_clear_set, write_one_clear_set} = 5'h10;
    cfgWord = 32'h0;
    bitSelect = ACC_READ_WRITE;
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    #1;
    chk("defaults", 32'hEF, {config_valid_flag, fixed_read_only, debugPinsOwned, resetPinEn,
      debugCfgEn, bootEn, readoutEn, debugActive});
    $display("Test reset values done");
    for (int i = 0; i < 17; i++)
    begin
      i_master.start(addrs[i], 1'h1, 32'h0);
      chk("target", tgts[i], targetSel);
      chk("miss", tgts[i] == TGT_NONE, decodeMiss);
      chk("ram", tgts[i] == TGT_RAM_LOW || tgts[i] == TGT_RAM_HIGH, ramSel);
      i_master.finish(rdData);
      if (tgts[i] == TGT_NONE)
        chk("reserved read", 32'h0, rdData);
    end
    @(posedge sys_clk);
    largeVariant <= 1'h0;
    i_master.start(32'h0003_0000, 1'h1, 32'h0);
    chk("small app area", {1'h0, 1'h1}, {appAreaSel, progStoreSel});
    i_master.finish(rdData);
    i_master.start(32'h0007_EEFF, 1'h1, 32'h0);
    chk("user cfg area", 32'h1, cfgUserArea);
    i_master.finish(rdData);
    i_master.start(32'h0007_EF00, 1'h1, 32'h0);
    chk("above user cfg area", 32'h0, cfgUserArea);
    i_master.finish(rdData);
    i_master.start(32'h4000_3810, 1'h1, 32'h0);
    chk("unit index", 32'h2, unitIndex);
    chk("reg offset", 32'h10, regOffset);
    i_master.finish(rdData);
    $display("Test address map done");
    for (int i = 0; i < 6; i++)
    begin
      @(posedge sys_clk);
      cfgWord <= cfgs[i];
      cfgLoad <= 1'h1;
      @(posedge sys_clk);
      cfgLoad <= 1'h0;
      #1;
      chk("cfg", cfgExp[i], {resetPinEn, debugCfgEn, bootEn, readoutEn, debugActive});
    end
    $display("Test configuration done");
    @(posedge sys_clk);
    {read_to_clear_set, write_one_clear_set} <= 2'h3;
    @(posedge sys_clk);
    {read_to_clear_set, write_one_clear_set} <= 2'h0;
    access(1'h1, 32'h0, ACC_READ_CLEAR);
    chk("rz read", {1'h1, 1'h0}, {rdData[0], read_to_clear});
    access(1'h0, 32'h0, ACC_WRITE_ONE);
    chk("w1c keep", 32'h1, write_one_clear);
    access(1'h0, 32'h1, ACC_WRITE_ONE);
    chk("w1c clear", 32'h0, write_one_clear);
    access(1'h0, 32'h1, ACC_SAFE_RW);
    chk("safe locked", 32'h0, safe_mode_write_readable);
    @(posedge sys_clk);
    safeMode <= 1'h1;
    access(1'h0, 32'h1, ACC_SAFE_RW);
    access(1'h1, 32'h0, ACC_SAFE_RW);
    chk("safe read", 32'h1, rdData[0]);
    access(1'h0, 32'h1, ACC_SAFE_WO);
    chk("write only bit", 32'h1, safe_mode_write_only);
    access(1'h1, 32'h0, ACC_SAFE_WO);
    chk("write only read", 32'h0, rdData[0]);
    access(1'h1, 32'h0, ACC_FIXED_RO);
    chk("fixed read", 32'h1, rdData[0]);
    $display("Test status bits done");
    give_verdict;
  end
endmodule : system_address_decoder_bench

//--- system_address_decoder_properties.sv
// Concurrent checks tying decoder outputs to their address, config and status causes
`timescale 1ns/1ps
module system_address_decoder_properties
  import addr_decoder_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [31:0] busAddr,
  input wire logic        busRead,
  input wire logic        busWrite,
  input wire logic [31:0] busWdata,
  input wire logic [31:0] busRdata,
  input wire logic        largeVariant,
  input wire logic [31:0] cfgWord,
  input wire logic        cfgLoad,
  input wire logic [3:0]  targetSel,
  input wire logic [1:0]  unitIndex,
  input wire logic [31:0] regOffset,
  input wire logic        progStoreSel,
  input wire logic        appAreaSel,
  input wire logic        ramSel,
  input wire logic        periphSel,
  input wire logic        scsSel,
  input wire logic        decodeMiss,
  input wire logic        resetPinEn,
  input wire logic        debugCfgEn,
  input wire logic        bootEn,
  input wire logic        readoutEn,
  input wire logic        debugActive,
  input wire logic        debugPinsOwned,
  input wire logic        safeMode,
  input wire logic        read_to_clear_set,
  input wire logic        write_one_clear_set,
  input wire logic [2:0]  bitSelect,
  input wire logic        read_to_clear,
  input wire logic        write_one_clear,
  input wire logic        safe_mode_write_readable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Address routing and unit decode
  a_code_route: assert property (busAddr < 32'h0008_0000 |-> progStoreSel)
    else $error("code address not routed to program store");
  a_ram_bank: assert property (busAddr >= 32'h2000_3800 && busAddr <= 32'h2000_7FFF |-> ramSel &&
    targetSel == (busAddr >= 32'h2000_7800 ? TGT_RAM_HIGH : TGT_RAM_LOW)) else $error("bad ram bank");
  a_periph_route: assert property (busAddr[31:16] == 16'h4000 |-> periphSel)
    else $error("peripheral window not selected");
  a_scs_route: assert property (busAddr >= 32'hE000_C000 && busAddr <= 32'hE000_FFFF |-> scsSel)
    else $error("system window not selected");
  a_app_area: assert property (busAddr[31:19] == 13'h0 |-> appAreaSel ==
    (busAddr <= (largeVariant ? 32'h0006_FFFF : 32'h0002_FFFF))) else $error("bad app area");
  a_timer_unit: assert property (busAddr[31:12] == 20'h40002 |-> targetSel == TGT_TIMER &&
    unitIndex == busAddr[11:10] && regOffset == {22'h0, busAddr[9:0]}) else $error("bad timer unit");
  a_reserved_read: assert property (busRead && targetSel == TGT_NONE |-> decodeMiss ##1
    busRdata == 32'h0) else $error("reserved read not zero");
  // Configuration word load and debug gating
  a_cfg_load: assert property (cfgLoad && cfgWord[31:28] == 4'h4 |=>
    {resetPinEn, debugCfgEn, bootEn, readoutEn} == {$past(cfgWord[3]), $past(cfgWord[4]),
    $past(cfgWord[6]), $past(cfgWord[7])}) else $error("config bits not loaded");
  a_cfg_reject: assert property (cfgLoad && cfgWord[31:28] != 4'h4 |=>
    $stable({resetPinEn, debugCfgEn, bootEn, readoutEn})) else $error("invalid config taken");
  a_debug_gate: assert property (debugActive == (debugCfgEn && !resetPinEn && readoutEn) &&
    debugPinsOwned == debugActive) else $error("debug gating wrong");
  // Status bit access kinds
  a_rz_clear: assert property (scsSel && busRead && bitSelect == ACC_READ_CLEAR &&
    !read_to_clear_set |=> busRdata[0] == $past(read_to_clear) && !read_to_clear)
    else $error("read clear bit wrong");
  a_w1c_write: assert property (scsSel && busWrite && bitSelect == ACC_WRITE_ONE &&
    !write_one_clear_set |=> write_one_clear == ($past(write_one_clear) && !$past(busWdata[0])))
    else $error("write one clear wrong");
  a_safe_hold: assert property (!safeMode |=> $stable(safe_mode_write_readable))
    else $error("protected bit changed outside safe mode");

  // Main scenarios reached
  c_rz_read: cover property (scsSel && busRead && bitSelect == ACC_READ_CLEAR && read_to_clear);
  c_safe_write: cover property (safeMode && busWrite && scsSel);
  c_miss: cover property (decodeMiss);
endmodule : system_address_decoder_properties

bind system_address_decoder system_address_decoder_properties i_props (.*);
